/* asc_pkg.sv */
// Constants, field layouts and state types for the serial control and status block
package asc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_CTRL3 = 8'h08;
  localparam logic [7:0] ADDR_STAT1 = 8'h0c;
  localparam logic [7:0] ADDR_DATA  = 8'h10;

  // First control register fields
  localparam int C1_MODULE_ON = 6;
  localparam int C1_CHAR9     = 4;
  localparam int C1_WAKE_ADDR = 3;

  // Second control register fields
  localparam int C2_TXE_IE    = 7;
  localparam int C2_TXC_IE    = 6;
  localparam int C2_RXF_IE    = 5;
  localparam int C2_IDLE_IE   = 4;
  localparam int C2_TX_EN     = 3;
  localparam int C2_RX_ON     = 2;
  localparam int C2_STANDBY   = 1;
  localparam int C2_SEND_BRK  = 0;

  // Third control register fields
  localparam int C3_RX9       = 7;
  localparam int C3_TX9       = 6;
  localparam int C3_OVR_IE    = 3;
  localparam int C3_NOISE_IE  = 2;
  localparam int C3_FRAME_IE  = 1;
  localparam int C3_PAR_IE    = 0;

  // Status register fields
  localparam int S1_EMPTY     = 7;
  localparam int S1_DONE      = 6;
  localparam int S1_FULL      = 5;
  localparam int S1_IDLE      = 4;
  localparam int S1_OVR       = 3;
  localparam int S1_NOISE     = 2;
  localparam int S1_FRAME     = 1;
  localparam int S1_PAR       = 0;
  localparam logic [7:0] SEEN_RX_MASK = 8'h3e;

  // Character lengths in bit times
  localparam logic [3:0] LEN8 = 4'ha;
  localparam logic [3:0] LEN9 = 4'hb;

  // Counter widths
  localparam int BAUD_W = 8;
  localparam int IDLE_W = 12;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PRE  = 2'b01,
    TX_DATA = 2'b11,
    TX_BRK  = 2'b10
  } asc_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11
  } asc_rx_e;

  // Data fields that reset leaves alone
  typedef struct packed {
    logic [7:0] rx_buf;
    logic [7:0] tx_hold;
    logic       rx9;
    logic       tx9;
  } asc_dat_s;

  typedef struct packed {
    logic              module_on;
    logic              char9;
    logic              wake_addr;
    logic              ie_txe;
    logic              ie_txc;
    logic              ie_rxf;
    logic              ie_idle;
    logic              tx_enable;
    logic              rx_on;
    logic              rx_standby;
    logic              send_brk;
    logic              ie_ovr;
    logic              ie_noise;
    logic              ie_frame;
    logic              ie_par;
    logic              empty;
    logic              done;
    logic              full;
    logic              idle;
    logic              ovr;
    logic              noise;
    logic              frame;
    logic [7:0]        seen;
    asc_tx_e           tx_state;
    logic [10:0]       tx_shift;
    logic [3:0]        tx_bits;
    logic [BAUD_W-1:0] tx_baud;
    logic              pre_pend;
    asc_rx_e           rx_state;
    logic [8:0]        rx_shift;
    logic [3:0]        rx_bits;
    logic [BAUD_W-1:0] rx_baud;
    logic [1:0]        rx_hist;
    logic              rx_nz;
    logic [IDLE_W-1:0] idle_cnt;
    logic              idle_armed;
    logic [7:0]        rd_data;
    logic              txd;
    logic              tx_irq;
    logic              rx_irq;
    logic              err_irq;
  } asc_ctl_s;

  typedef struct packed {
    asc_dat_s dat;
    asc_ctl_s ctl;
  } asc_state_s;

  localparam asc_ctl_s CTL_RST = '{empty: 1'b1, done: 1'b1, txd: 1'b1, rx_hist: 2'b11,
                                   tx_state: TX_IDLE, rx_state: RX_IDLE, default: '0};

endpackage

/* asc_ctrl.sv */
// Serial interface control, status and character engine
//
// Operation
// - Idle flag interrupts when idle enable set
// - Enabling transmitter sends one all-ones preamble, none if the enable lands on an idle bit tick or a break starts first
// - Disabling transmitter finishes character, line high
// - Re-enable mid-character queues one idle character
// - Receiver disable keeps flags; reset clears it
// - Standby suppresses receive and error interrupts; wake clears standby
// - Break then high bit; held breaks back-to-back
// - Received ninth bit, or bit 7 copy
// - Ninth transmit bit loads with data byte
// - Each error flag gated by own enable
// - Empty sets on load; read-then-write clears
// - Done while empty and nothing being sent
// - Full sets on receive; read-then-read clears
// - Idle after full-character high; read-read clears
// - Idle re-arms only after a full flag
// - Overrun keeps buffer, drops new character
// - Overrun clears only if status saw it
// - Noise flag sets, interrupts, read-read clears
// - Length bit selects ten or eleven bits
// - Wake bit selects address mark or idle
// - Module off sets empty, done; no tx irq
`timescale 1ns/1ns
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  output logic            txd,
  input  wire logic       rxd,
  output logic            tx_irq,
  output logic            rx_irq,
  output logic            err_irq
);

  localparam logic [BAUD_W-1:0] BIT_LAST  = BAUD_W'(BIT_CYCLES - 1);
  localparam logic [BAUD_W-1:0] HALF_LAST = BAUD_W'(BIT_CYCLES / 2 - 1);

  asc_state_s        st;
  asc_state_s        n;
  logic [3:0]        flen;
  logic [IDLE_W-1:0] idle_tgt;
  logic [7:0]        stat_v;
  logic [7:0]        c1_v;
  logic [7:0]        c2_v;
  logic [7:0]        c3_v;
  logic              tx_tick;
  logic              rx_tick;
  logic              mj;
  logic              noisy;
  logic              load_now;

  always_comb begin
    n        = st;
    load_now = 1'b0;
    flen     = st.ctl.char9 ? LEN9 : LEN8;
    idle_tgt = IDLE_W'(flen) * IDLE_W'(BIT_CYCLES);
    tx_tick  = st.ctl.tx_baud == '0;
    rx_tick  = st.ctl.rx_baud == '0;
    mj       = (st.ctl.rx_hist[1] & st.ctl.rx_hist[0]) | (st.ctl.rx_hist[1] & rxd) | (st.ctl.rx_hist[0] & rxd);
    noisy    = !((st.ctl.rx_hist[1] == st.ctl.rx_hist[0]) && (st.ctl.rx_hist[0] == rxd));

    // Register images
    stat_v = '0;
    stat_v[S1_EMPTY] = st.ctl.empty;
    stat_v[S1_DONE]  = st.ctl.done;
    stat_v[S1_FULL]  = st.ctl.full;
    stat_v[S1_IDLE]  = st.ctl.idle;
    stat_v[S1_OVR]   = st.ctl.ovr;
    stat_v[S1_NOISE] = st.ctl.noise;
    stat_v[S1_FRAME] = st.ctl.frame;
    c1_v = '0;
    c1_v[C1_MODULE_ON] = st.ctl.module_on;
    c1_v[C1_CHAR9]     = st.ctl.char9;
    c1_v[C1_WAKE_ADDR] = st.ctl.wake_addr;
    c2_v = '0;
    c2_v[C2_TXE_IE]   = st.ctl.ie_txe;
    c2_v[C2_TXC_IE]   = st.ctl.ie_txc;
    c2_v[C2_RXF_IE]   = st.ctl.ie_rxf;
    c2_v[C2_IDLE_IE]  = st.ctl.ie_idle;
    c2_v[C2_TX_EN]    = st.ctl.tx_enable;
    c2_v[C2_RX_ON]    = st.ctl.rx_on;
    c2_v[C2_STANDBY]  = st.ctl.rx_standby;
    c2_v[C2_SEND_BRK] = st.ctl.send_brk;
    c3_v = '0;
    c3_v[C3_RX9]      = st.dat.rx9;
    c3_v[C3_TX9]      = st.dat.tx9;
    c3_v[C3_OVR_IE]   = st.ctl.ie_ovr;
    c3_v[C3_NOISE_IE] = st.ctl.ie_noise;
    c3_v[C3_FRAME_IE] = st.ctl.ie_frame;
    c3_v[C3_PAR_IE]   = st.ctl.ie_par;

    // Register writes
    if (wr_en) begin
      case (addr)
        ADDR_CTRL1: begin
          n.ctl.module_on = wr_data[C1_MODULE_ON];
          n.ctl.char9     = wr_data[C1_CHAR9];
          n.ctl.wake_addr = wr_data[C1_WAKE_ADDR];
        end
        ADDR_CTRL2: begin
          n.ctl.ie_txe     = wr_data[C2_TXE_IE];
          n.ctl.ie_txc     = wr_data[C2_TXC_IE];
          n.ctl.ie_rxf     = wr_data[C2_RXF_IE];
          n.ctl.ie_idle    = wr_data[C2_IDLE_IE];
          n.ctl.rx_standby = wr_data[C2_STANDBY];
          n.ctl.send_brk   = wr_data[C2_SEND_BRK];
          if (st.ctl.module_on) begin
            n.ctl.tx_enable = wr_data[C2_TX_EN];
            n.ctl.rx_on     = wr_data[C2_RX_ON];
            if (wr_data[C2_TX_EN] && !st.ctl.tx_enable) begin
              n.ctl.pre_pend = 1'b1;
            end
            if (wr_data[C2_RX_ON] && !st.ctl.rx_on) begin
              n.ctl.idle_armed = 1'b0;
            end
          end
        end
        ADDR_CTRL3: begin
          // bits 5 and 4 not stored
          n.dat.tx9       = wr_data[C3_TX9];
          n.ctl.ie_ovr    = wr_data[C3_OVR_IE];
          n.ctl.ie_noise  = wr_data[C3_NOISE_IE];
          n.ctl.ie_frame  = wr_data[C3_FRAME_IE];
          n.ctl.ie_par    = wr_data[C3_PAR_IE];
        end
        ADDR_DATA: begin
          n.dat.tx_hold = wr_data;
          if (st.ctl.seen[S1_EMPTY]) begin
            n.ctl.empty = 1'b0;
          end
          n.ctl.seen[S1_EMPTY] = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Register reads
    n.ctl.rd_data = '0;
    if (rd_en) begin
      case (addr)
        ADDR_CTRL1: n.ctl.rd_data = c1_v;
        ADDR_CTRL2: n.ctl.rd_data = c2_v;
        ADDR_CTRL3: n.ctl.rd_data = c3_v;
        ADDR_STAT1: begin
          n.ctl.rd_data = stat_v;
          n.ctl.seen    = stat_v;
        end
        ADDR_DATA: begin
          n.ctl.rd_data = st.dat.rx_buf;
          if (st.ctl.seen[S1_FULL]) n.ctl.full = 1'b0;
          if (st.ctl.seen[S1_IDLE]) n.ctl.idle = 1'b0;
          if (st.ctl.seen[S1_OVR]) n.ctl.ovr = 1'b0;
          if (st.ctl.seen[S1_NOISE]) n.ctl.noise = 1'b0;
          if (st.ctl.seen[S1_FRAME]) n.ctl.frame = 1'b0;
          n.ctl.seen = st.ctl.seen & ~SEEN_RX_MASK;
        end
        default: n.ctl.rd_data = '0;
      endcase
    end

    // Transmitter
    if (!st.ctl.module_on) begin
      n.ctl.empty    = 1'b1;
      n.ctl.tx_state = TX_IDLE;
      n.ctl.tx_baud  = BIT_LAST;
      n.ctl.pre_pend = 1'b0;
    end else begin
      n.ctl.tx_baud = tx_tick ? BIT_LAST : st.ctl.tx_baud - 1'b1;
      if (tx_tick) begin
        if (st.ctl.tx_state != TX_IDLE && st.ctl.tx_bits != 4'h1) begin
          n.ctl.tx_shift = {st.ctl.tx_state != TX_BRK, st.ctl.tx_shift[10:1]};
          n.ctl.tx_bits  = st.ctl.tx_bits - 1'b1;
        end else if (st.ctl.tx_state == TX_BRK && !st.ctl.send_brk) begin
          // one high bit after last break
          n.ctl.tx_state = TX_IDLE;
        end else if (st.ctl.send_brk && st.ctl.tx_enable) begin
          n.ctl.tx_state = TX_BRK;
          n.ctl.tx_shift = '0;
          n.ctl.tx_bits  = flen;
          n.ctl.pre_pend = 1'b0;
        end else if (st.ctl.pre_pend && st.ctl.tx_enable) begin
          n.ctl.tx_state = TX_PRE;
          n.ctl.tx_shift = '1;
          n.ctl.tx_bits  = flen;
          n.ctl.pre_pend = 1'b0;
        end else if (!st.ctl.empty && st.ctl.tx_enable) begin
          load_now       = 1'b1;
          n.ctl.tx_state = TX_DATA;
          n.ctl.tx_shift = st.ctl.char9 ? {1'b1, st.dat.tx9, st.dat.tx_hold, 1'b0}
                                        : {2'b11, st.dat.tx_hold, 1'b0};
          n.ctl.tx_bits  = flen;
          n.ctl.empty    = 1'b1;
        end else begin
          n.ctl.tx_state = TX_IDLE;
          n.ctl.pre_pend = n.ctl.pre_pend & st.ctl.tx_enable;
        end
      end
    end
    n.ctl.txd = (n.ctl.tx_state == TX_IDLE) ? 1'b1 : n.ctl.tx_shift[0];
    // done when idle and nothing queued
    n.ctl.done = n.ctl.empty && n.ctl.tx_state == TX_IDLE && !n.ctl.pre_pend
                 && !(n.ctl.send_brk && n.ctl.tx_enable && n.ctl.module_on);

    // Receiver
    n.ctl.rx_hist = {st.ctl.rx_hist[0], rxd};
    if (!st.ctl.module_on || !st.ctl.rx_on) begin
      n.ctl.rx_state = RX_IDLE;
      n.ctl.idle_cnt = '0;
    end else begin
      if (!rxd) begin
        n.ctl.idle_cnt = '0;
      end else if (st.ctl.idle_cnt != idle_tgt) begin
        n.ctl.idle_cnt = st.ctl.idle_cnt + 1'b1;
        if (st.ctl.idle_cnt == idle_tgt - 1'b1) begin
          if (st.ctl.rx_standby) begin
            if (!st.ctl.wake_addr) n.ctl.rx_standby = 1'b0;
          end else if (st.ctl.idle_armed) begin
            n.ctl.idle       = 1'b1;
            n.ctl.idle_armed = 1'b0;
          end
        end
      end
      case (st.ctl.rx_state)
        RX_IDLE: begin
          if (!rxd) begin
            n.ctl.rx_state = RX_START;
            n.ctl.rx_baud  = HALF_LAST;
          end
        end
        RX_START: begin
          n.ctl.rx_baud = st.ctl.rx_baud - 1'b1;
          if (rx_tick) begin
            n.ctl.rx_state = mj ? RX_IDLE : RX_DATA;
            n.ctl.rx_baud  = BIT_LAST;
            n.ctl.rx_bits  = flen - 1'b1;
            n.ctl.rx_nz    = noisy;
          end
        end
        RX_DATA: begin
          n.ctl.rx_baud = st.ctl.rx_baud - 1'b1;
          if (rx_tick) begin
            n.ctl.rx_baud = BIT_LAST;
            n.ctl.rx_nz   = st.ctl.rx_nz | noisy;
            if (st.ctl.rx_bits != 4'h1) begin
              n.ctl.rx_shift = {mj, st.ctl.rx_shift[8:1]};
              n.ctl.rx_bits  = st.ctl.rx_bits - 1'b1;
            end else begin
              n.ctl.rx_state = RX_IDLE;
              if (!st.ctl.rx_standby || (st.ctl.wake_addr && st.ctl.rx_shift[8])) begin
                n.ctl.rx_standby = 1'b0;
                if (st.ctl.full) begin
                  n.ctl.ovr = 1'b1;
                end else begin
                  n.dat.rx_buf     = st.ctl.char9 ? st.ctl.rx_shift[7:0] : st.ctl.rx_shift[8:1];
                  n.dat.rx9        = st.ctl.rx_shift[8];
                  n.ctl.full       = 1'b1;
                  n.ctl.noise      = n.ctl.noise | st.ctl.rx_nz | noisy;
                  n.ctl.frame      = n.ctl.frame | !mj;
                  n.ctl.idle_armed = 1'b1;
                end
              end
            end
          end
        end
        default: n.ctl.rx_state = RX_IDLE;
      endcase
    end

    // Interrupt requests
    // transmitter requests need module on
    n.ctl.tx_irq  = n.ctl.module_on && ((n.ctl.empty && n.ctl.ie_txe) || (n.ctl.done && n.ctl.ie_txc));
    n.ctl.rx_irq  = !n.ctl.rx_standby && ((n.ctl.full && n.ctl.ie_rxf) || (n.ctl.idle && n.ctl.ie_idle));
    n.ctl.err_irq = !n.ctl.rx_standby && ((n.ctl.ovr && n.ctl.ie_ovr) || (n.ctl.noise && n.ctl.ie_noise)
                    || (n.ctl.frame && n.ctl.ie_frame));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st.ctl <= CTL_RST;
    end else begin
      st <= n;
    end
  end

  assign rd_data = st.ctl.rd_data;
  assign txd     = st.ctl.txd;
  assign tx_irq  = st.ctl.tx_irq;
  assign rx_irq  = st.ctl.rx_irq;
  assign err_irq = st.ctl.err_irq;

  // Checks
  localparam int A_PRE_MAX = 2 * BIT_CYCLES + 2;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_stat_ovr_clear;
    !st.ctl.seen[S1_OVR];
  endsequence
  sequence s_data_rd_ovr_set;
    rd_en && addr == ADDR_DATA && st.ctl.ovr;
  endsequence

  a_idle_irq_gate: assert property ((st.ctl.idle && st.ctl.ie_idle && !st.ctl.rx_standby) |-> rx_irq)
    else $error("idle flag enabled but no receiver request");
  a_pre_start: assert property (($rose(st.ctl.tx_enable) && st.ctl.tx_state == TX_IDLE && !st.ctl.send_brk)
    |-> ##[1:A_PRE_MAX] (st.ctl.tx_state == TX_PRE))
    else $error("preamble did not start after enable");
  a_idle_line_high: assert property ((st.ctl.tx_state == TX_IDLE) |-> txd)
    else $error("transmit line low while idle");
  a_brk_line_low: assert property ((st.ctl.tx_state == TX_BRK) |-> !txd)
    else $error("transmit line high during break");
  a_standby_quiet: assert property (st.ctl.rx_standby |-> (!rx_irq && !err_irq))
    else $error("receiver request during standby");
  a_rx_off_keep: assert property ((!st.ctl.rx_on && !(rd_en && addr == ADDR_DATA)) |=> $stable(st.ctl.full))
    else $error("full flag changed with receiver off");
  a_ninth_mirror: assert property (($rose(st.ctl.full) && !st.ctl.char9) |-> st.dat.rx9 == st.dat.rx_buf[7])
    else $error("ninth bit does not mirror bit 7");
  a_ovr_keep_buf: assert property ($rose(st.ctl.ovr) |-> $stable(st.dat.rx_buf))
    else $error("buffer changed on overrun");
  a_ovr_late_read: assert property ((s_stat_ovr_clear ##0 s_data_rd_ovr_set) |=> st.ctl.ovr)
    else $error("overrun cleared without status read seeing it");
  a_empty_clear: assert property ((wr_en && addr == ADDR_DATA && st.ctl.seen[S1_EMPTY] && !load_now
    && st.ctl.module_on) |=> !st.ctl.empty)
    else $error("empty flag not cleared by data write");
  a_done_needs_empty: assert property (st.ctl.done |-> (st.ctl.empty && st.ctl.tx_state == TX_IDLE))
    else $error("done set while sending");
  a_module_off: assert property ((!st.ctl.module_on && $past(!st.ctl.module_on))
    |-> (st.ctl.empty && st.ctl.done && !tx_irq))
    else $error("module off without empty and done");
  a_noise_irq: assert property ((st.ctl.noise && st.ctl.ie_noise && !st.ctl.rx_standby) |-> err_irq)
    else $error("noise flag enabled but no error request");

endmodule // asc_ctrl

/* asc_remote.sv */
// Remote serial transceiver model facing the block's serial pins
`timescale 1ns/1ns
module asc_remote #(
  parameter int BIT_CYCLES = 8
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);

  initial begin
    rxd = 1'b1;
  end

  // Start, data LSB first, stop; the noisy data bit toggles every clock
  task automatic send(input logic [8:0] d, input int nb, input int noisy);
    logic b;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : ((i > nb) ? 1'b1 : d[i-1]);
      for (int k = 0; k < BIT_CYCLES; k++) begin
        rxd <= (i == noisy + 1) ? k[0] : b;
        @(posedge clk);
      end
    end
  endtask

  // Waits for a start bit, then samples each following bit at its centre
  task automatic recv(output logic [10:0] w, output int n, input int nb);
    n = 0;
    w = '0;
    while (txd !== 1'b0 && n < 60 * BIT_CYCLES) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < nb + 2; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      w[i] = txd;
    end
  endtask

endmodule // asc_remote

/* testbench.sv */
// Self-checking bench for the serial control and status block
`timescale 1ns/1ns
module testbench
  import asc_pkg::*;
;
  localparam int BC = 8;

  logic       clk;
  logic       rst_b;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  wire  [7:0] rd_data;
  wire        txd;
  wire        rxd;
  wire        tx_irq;
  wire        rx_irq;
  wire        err_irq;
  int         error_cnt;
  int         num_checks;

  asc_ctrl #(.BIT_CYCLES(BC)) asc_ctrl_inst (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .txd(txd), .rxd(rxd), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq)
  );

  asc_remote #(.BIT_CYCLES(BC)) asc_remote_inst (.clk(clk), .txd(txd), .rxd(rxd));

  initial begin
    clk = 1'b0;
  end
  always #10 clk = ~clk;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(name, {8'h00, v & m}, {8'h00, exp});
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  task automatic t_reset_vals;
    do_reset;
    chk("irqs", {13'h0, tx_irq, rx_irq, err_irq}, 16'h0);
    rchk("ctrl1", ADDR_CTRL1, 8'hff, 8'h00);
    rchk("ctrl2", ADDR_CTRL2, 8'hff, 8'h00);
    rchk("ctrl3", ADDR_CTRL3, 8'h3f, 8'h00);
    rchk("status", ADDR_STAT1, 8'hff, 8'hc0);
    rchk("unmapped", 8'h14, 8'hff, 8'h00);
  endtask

  task automatic t_transmit;
    logic [10:0] w;
    int          n;
    do_reset;
    wr(ADDR_CTRL1, 8'h50);
    // bits 5 and 4 left clear
    wr(ADDR_CTRL3, 8'h40);
    wr(ADDR_CTRL2, 8'h88);
    rchk("preamble_queued", ADDR_STAT1, 8'hc0, 8'h80);
    fork
      asc_remote_inst.recv(w, n, 9);
      begin
        wr(ADDR_DATA, 8'ha5);
        rchk("loaded", ADDR_STAT1, 8'hc0, 8'h00);
      end
    join
    chk("preamble_len", {15'h0, n >= 11 * BC - 2 && n <= 12 * BC + 1}, 16'h1);
    chk("frame9", {5'h0, w}, 16'h07a5);
    rchk("sent", ADDR_STAT1, 8'hc0, 8'hc0);
    chk("tx_irq", {15'h0, tx_irq}, 16'h1);
    fork
      asc_remote_inst.recv(w, n, 9);
      begin
        wr(ADDR_CTRL2, 8'h89);
        repeat (2 * BC) @(posedge clk);
        wr(ADDR_CTRL2, 8'h88);
      end
    join
    chk("break", {5'h0, w}, 16'h0400);
    fork
      asc_remote_inst.recv(w, n, 9);
      begin
        wr(ADDR_DATA, 8'h3c);
        repeat (4 * BC) @(posedge clk);
        wr(ADDR_CTRL2, 8'h80);
      end
    join
    chk("finish_char", {5'h0, w}, 16'h073c);
    rchk("empty_again", ADDR_STAT1, 8'hc0, 8'hc0);
    wr(ADDR_DATA, 8'h5a);
    rchk("held", ADDR_STAT1, 8'h80, 8'h00);
    wr(ADDR_CTRL1, 8'h00);
    rchk("module_off", ADDR_STAT1, 8'hc0, 8'hc0);
    chk("tx_irq_off", {15'h0, tx_irq}, 16'h0);
  endtask

  task automatic t_receive;
    logic [7:0] v;
    do_reset;
    wr(ADDR_CTRL1, 8'h40);
    wr(ADDR_CTRL2, 8'h24);
    wr(ADDR_CTRL3, 8'h08);
    repeat (12 * BC) @(posedge clk);
    rchk("unarmed", ADDR_STAT1, 8'hff, 8'hc0);
    asc_remote_inst.send(9'h096, 8, 99);
    rchk("full", ADDR_STAT1, 8'hff, 8'he0);
    chk("rx_irq", {15'h0, rx_irq}, 16'h1);
    rchk("ninth", ADDR_CTRL3, 8'h80, 8'h80);
    wr(ADDR_CTRL2, 8'h14);
    repeat (12 * BC) @(posedge clk);
    rchk("idle", ADDR_STAT1, 8'hff, 8'hf0);
    chk("idle_irq", {15'h0, rx_irq}, 16'h1);
    rchk("data", ADDR_DATA, 8'hff, 8'h96);
    rchk("cleared", ADDR_STAT1, 8'hff, 8'hc0);
    chk("rx_irq_low", {15'h0, rx_irq}, 16'h0);
    asc_remote_inst.send(9'h011, 8, 99);
    asc_remote_inst.send(9'h022, 8, 99);
    rchk("overrun", ADDR_STAT1, 8'hff, 8'he8);
    chk("err_irq", {15'h0, err_irq}, 16'h1);
    rchk("kept", ADDR_DATA, 8'hff, 8'h11);
    rchk("ovr_clear", ADDR_STAT1, 8'hff, 8'hc0);
    asc_remote_inst.send(9'h033, 8, 99);
    rchk("full_only", ADDR_STAT1, 8'hff, 8'he0);
    asc_remote_inst.send(9'h044, 8, 99);
    rchk("kept_late", ADDR_DATA, 8'hff, 8'h33);
    rchk("ovr_stays", ADDR_STAT1, 8'hff, 8'hc8);
    rd(ADDR_DATA, v);
    rchk("ovr_gone", ADDR_STAT1, 8'hff, 8'hc0);
    wr(ADDR_CTRL3, 8'h04);
    asc_remote_inst.send(9'h0f0, 8, 3);
    rchk("noise", ADDR_STAT1, 8'hff, 8'he4);
    chk("noise_irq", {15'h0, err_irq}, 16'h1);
    wr(ADDR_CTRL2, 8'h10);
    rchk("rx_off_keeps", ADDR_STAT1, 8'hff, 8'he4);
    rd(ADDR_DATA, v);
    rchk("noise_clear", ADDR_STAT1, 8'hff, 8'hc0);
    chk("err_irq_low", {15'h0, err_irq}, 16'h0);
  endtask

  task automatic t_standby;
    do_reset;
    wr(ADDR_CTRL1, 8'h48);
    wr(ADDR_CTRL2, 8'h26);
    asc_remote_inst.send(9'h011, 8, 99);
    rchk("asleep", ADDR_STAT1, 8'hff, 8'hc0);
    rchk("still_standby", ADDR_CTRL2, 8'h02, 8'h02);
    chk("quiet", {15'h0, rx_irq}, 16'h0);
    asc_remote_inst.send(9'h085, 8, 99);
    rchk("addr_wake", ADDR_STAT1, 8'hff, 8'he0);
    rchk("addr_woken", ADDR_CTRL2, 8'h02, 8'h00);
    chk("wake_irq", {15'h0, rx_irq}, 16'h1);
    wr(ADDR_CTRL1, 8'h40);
    wr(ADDR_CTRL2, 8'h06);
    repeat (12 * BC) @(posedge clk);
    rchk("idle_woken", ADDR_CTRL2, 8'h02, 8'h00);
    rchk("wake_no_idle", ADDR_STAT1, 8'hff, 8'he0);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("mismatch watchdog expected done seen timeout");
    wrap_up;
  end

  initial begin
    addr       = 8'h00;
    wr_data    = 8'h00;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    rst_b      = 1'b0;
    error_cnt  = 0;
    num_checks = 0;
    t_reset_vals;
    t_transmit;
    t_receive;
    t_standby;
    wrap_up;
  end

endmodule // testbench
